// >>> dv/oscillator_select_and_divider_bench.sv
`timescale 1ns/1ps
module oscillator_select_and_divider_bench;
    import osd_pkg::*;
    localparam logic [31:0] A_OSC = {28'h0, ADDR_OSC_CTRL};
    localparam logic [31:0] A_DIV = {28'h0, ADDR_CLK_DIV};
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
    logic [3:0]  pstrb = 4'h0;
    logic [1:0]  tdiv = 2'h0, switch_monitor_cfg = 2'h0;
    logic [2:0]  initial_source_cfg = 3'h7, active_source, doze, usbd, cfg;
    logic [2:0]  tgt;
    logic        new_src_clk_pin = 1'b0, sleep_mode = 1'b0;
    logic        interrupt_event = 1'b0, fail_pin = 1'b0;
    logic        pready, pslverr, fsm_on, pri_on, sec_on, pll_on, io_lock;
    logic        misuse;
    logic [7:0]  rcd;
    logic [15:0] w;
    logic [31:0] exp_q[$], msk_q[$];
    int          errors = 0, num_checks = 0;

    osd_top dut_u (.clock(clock), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .switch_monitor_cfg(switch_monitor_cfg), .primary_mode_cfg(2'b01),
        .initial_source_cfg(initial_source_cfg), .io_lock_one_way_cfg(1'b1),
        .pll_locked_pin(1'b1), .osc_ready_pin(1'b1),
        .new_src_clk_pin(new_src_clk_pin), .clock_failure_pin(fail_pin),
        .sleep_mode(sleep_mode), .interrupt_event(interrupt_event),
        .usb_enabled(1'b1), .active_source(active_source),
        .fail_safe_monitor(fsm_on), .primary_osc_on(pri_on),
        .secondary_osc_on(sec_on), .pll_on(pll_on), .io_lock_a(io_lock),
        .doze_ratio_log2(doze), .rc_divisor_m1(rcd),
        .usb_branch_div_log2(usbd), .usb_div_misuse(misuse));

    initial
    begin
        forever #5 clock = ~clock;
    end

    // New-source clock, one rise every 8 cycles
    always @(posedge clock)
    begin
        tdiv <= tdiv + 2'h1;
        if (tdiv == 2'h3)
            new_src_clk_pin <= ~new_src_clk_pin;
    end

    task automatic chk(input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Read data taken at the access edge
    always @(posedge clock)
    begin
        if (psel && penable && !pwrite && pready === 1'b1)
            chk(prdata & msk_q.pop_front(), exp_q.pop_front());
    end

    task results;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task xfer(input logic wr_n, input logic [31:0] a, d, input logic [3:0] s);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr_n;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1)
            @(posedge clock);
    endtask

    task rel;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task wr(input logic [31:0] a, d, input logic [3:0] s);
        xfer(1'b1, a, d, s);
        rel;
    endtask

    task rd(input logic [31:0] a, e, m);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        xfer(1'b0, a, 32'h0, 4'h0);
        rel;
    endtask

    task key(input logic hi, input logic [7:0] v);
        int sh;
        logic [3:0] s;
        sh = hi ? 8 : 0;
        s = hi ? 4'h2 : 4'h1;
        xfer(1'b1, A_OSC, 32'(hi ? KEY_HI_1 : KEY_LO_1) << sh, s);
        xfer(1'b1, A_OSC, 32'(hi ? KEY_HI_2 : KEY_LO_2) << sh, s);
        xfer(1'b1, A_OSC, 32'(v) << sh, s);
        rel;
    endtask

    task do_reset(input logic [2:0] c, input logic [1:0] sm);
        rst_n <= 1'b0;
        initial_source_cfg <= c;
        switch_monitor_cfg <= sm;
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
    endtask

    function automatic logic [31:0] osc(input logic [2:0] c, n,
                                        input logic [7:0] lo);
        return {17'h0, c, 1'b0, n, lo};
    endfunction

    initial
    begin
        int unsigned seed;
        logic [2:0] c3;
        int n;
        seed = $urandom(46840);
        do_reset(SRC_FRC_DIV, 2'b00);
        rd(A_OSC, osc(3'h7, 3'h7, 8'h00), 32'hffff_ffff);
        chk(fsm_on, 1'b1);
        rd(A_DIV, {16'h0, CLK_DIV_RESET}, 32'hffff_ffff);
        for (int i = 0; i < 8; i++)
        begin
            c3 = i[2:0];
            w = {1'b0, c3, c3[0], c3, c3[1:0], c3[0], 5'h0};
            wr(A_DIV, {16'h0, w}, 4'hf);
            rd(A_DIV, {16'h0, w}, 32'hffff_ffff);
            chk(doze, c3[0] ? c3 : 3'h0);
            chk(rcd, (c3 == 3'h7) ? 8'hff : (8'h1 << c3) - 8'h1);
            chk(usbd, c3[1:0]);
            chk(misuse, c3[1]);
            chk(pll_on, c3[0]);
        end
        w = 16'($urandom());
        wr(A_DIV, {16'h0, w}, 4'hf);
        rd(A_DIV, {16'h0, w & CLK_DIV_WMASK}, 32'hffff_ffff);
        for (int r = 1; r >= 0; r--)
        begin
            w = {r[0], 3'h5, 1'b1, 11'h0};
            wr(A_DIV, {16'h0, w}, 4'hf);
            interrupt_event <= 1'b1;
            @(posedge clock);
            interrupt_event <= 1'b0;
            @(posedge clock);
            chk(doze, r[0] ? 3'h0 : 3'h5);
            w[11] = ~r[0];
            rd(A_DIV, {16'h0, w}, 32'hffff_ffff);
        end
        tgt = SRC_PRI;
        key(1'b1, {5'h0, tgt});
        key(1'b0, 8'h07);
        for (n = 0; n < 500 && active_source !== tgt; n++)
            @(posedge clock);
        chk(active_source, tgt);
        rd(A_OSC, osc(tgt, tgt, 8'h06), 32'hffff_ffff);
        chk(sec_on, 1'b1);
        sleep_mode <= 1'b1;
        repeat (2) @(posedge clock);
        chk(pri_on, 1'b1);
        key(1'b0, 8'h07);
        repeat (20) @(posedge clock);
        rd(A_OSC, osc(tgt, tgt, 8'h06), 32'hffff_ffff);
        wr(A_OSC, 32'h0, 4'h2);
        rd(A_OSC, osc(tgt, tgt, 8'h06), 32'hffff_ffff);
        key(1'b0, 8'hc0);
        chk(pri_on, 1'b0);
        fail_pin <= 1'b1;
        repeat (3) @(posedge clock);
        fail_pin <= 1'b0;
        rd(A_OSC, osc(tgt, tgt, 8'hc8), 32'hffff_ffff);
        key(1'b0, 8'h00);
        key(1'b1, 8'h00);
        rd(A_OSC, osc(tgt, tgt, 8'hc0), 32'hffff_ffff);
        chk(io_lock, 1'b1);
        wr(32'h8, 32'h0, 4'hf);
        sleep_mode <= 1'b0;
        cfg = 3'($urandom());
        if (cfg == SRC_RSVD)
            cfg = SRC_FRC;
        do_reset(cfg, {1'b1, 1'($urandom())});
        rd(A_OSC, osc(cfg, cfg, 8'h00), 32'hffff_ffff);
        chk(fsm_on, 1'b0);
        tgt = (cfg == SRC_FRC) ? SRC_LOW_POWER_RC : SRC_FRC;
        key(1'b1, {5'h0, tgt});
        key(1'b0, 8'h01);
        repeat (100) @(posedge clock);
        chk(active_source, cfg);
        rd(A_OSC, osc(cfg, 3'h0, 8'h00), 32'h7001);
        repeat (3) @(posedge clock);
        results;
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        errors++;
        results;
    end
endmodule // oscillator_select_and_divider_bench

// >>> dv/osd_monitor.sv
`timescale 1ns/1ps
module osd_monitor
(
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [1:0]  switch_monitor_cfg,
    input wire logic [2:0]  initial_source_cfg,
    input wire logic        io_lock_one_way_cfg,
    input wire logic        new_src_clk_pin,
    input wire logic        usb_enabled,
    input wire logic [2:0]  active_source,
    input wire logic        fail_safe_monitor,
    input wire logic        io_lock_a,
    input wire logic [7:0]  rc_divisor_m1,
    input wire logic [2:0]  usb_branch_div_log2,
    input wire logic        usb_div_misuse
);
    logic       tick_q_reg;
    logic [2:0] src_q_reg;
    logic [3:0] tick_cnt_reg;

    // Raw settle ticks since the last source change or the last access to address 0
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_q_reg   <= 1'b0;
            src_q_reg    <= 3'h7;
            tick_cnt_reg <= 4'h0;
        end
        else
        begin
            tick_q_reg <= new_src_clk_pin;
            src_q_reg  <= active_source;
            if (psel && penable && paddr == 32'h0)
                tick_cnt_reg <= 4'h0;
            else if (src_q_reg != active_source)
                tick_cnt_reg <= 4'h0;
            else if (new_src_clk_pin && !tick_q_reg && tick_cnt_reg != 4'hf)
                tick_cnt_reg <= tick_cnt_reg + 4'h1;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_rel;
        $rose(rst_n) ##1 1'b1;
    endsequence
    property p_por;
        s_rel |-> active_source == initial_source_cfg;
    endproperty
    property p_fsm;
        fail_safe_monitor == (switch_monitor_cfg == 2'b00);
    endproperty
    property p_rsvd;
        active_source != 3'h6;
    endproperty
    property p_oneway;
        io_lock_one_way_cfg && io_lock_a |=> io_lock_a;
    endproperty
    property p_rc_postscaler;
        rc_divisor_m1 inside {8'h00, 8'h01, 8'h03, 8'h07,
                              8'h0f, 8'h1f, 8'h3f, 8'hff};
    endproperty
    property p_usb_branch_sysclk_div;
        usb_branch_div_log2 <= 3'h3;
    endproperty
    property p_misuse;
        usb_div_misuse == (usb_enabled && usb_branch_div_log2 >= 3'h2);
    endproperty
    property p_fixed;
        switch_monitor_cfg[1] && $past(rst_n) |=> $stable(active_source);
    endproperty
    property p_settle;
        $changed(active_source) && $past(rst_n, 2) |-> tick_cnt_reg >= 4'ha;
    endproperty
    property p_err;
        psel && penable |->
            pready && pslverr == (paddr != 32'h0 && paddr != 32'h4);
    endproperty

    a_por: assert property (p_por)
        else $error("source after reset wrong");
    a_fsm: assert property (p_fsm)
        else $error("monitor enable wrong");
    a_rsvd: assert property (p_rsvd)
        else $error("reserved source active");
    a_oneway: assert property (p_oneway)
        else $error("io lock cleared");
    a_rc_postscaler: assert property (p_rc_postscaler)
        else $error("bad rc divisor");
    a_usb_branch_sysclk_div: assert property (p_usb_branch_sysclk_div)
        else $error("bad usb divider");
    a_misuse: assert property (p_misuse)
        else $error("misuse flag wrong");
    a_fixed: assert property (p_fixed)
        else $error("source moved while disabled");
    a_settle: assert property (p_settle)
        else $error("switch before settle clocks");
    a_err: assert property (p_err)
        else $error("bus answer wrong");
endmodule // osd_monitor

bind osd_top osd_monitor mon_u (.clock(clock), .rst_n(rst_n),
    .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
    .pslverr(pslverr), .switch_monitor_cfg(switch_monitor_cfg),
    .initial_source_cfg(initial_source_cfg),
    .io_lock_one_way_cfg(io_lock_one_way_cfg),
    .new_src_clk_pin(new_src_clk_pin), .usb_enabled(usb_enabled),
    .active_source(active_source), .fail_safe_monitor(fail_safe_monitor),
    .io_lock_a(io_lock_a), .rc_divisor_m1(rc_divisor_m1),
    .usb_branch_div_log2(usb_branch_div_log2),
    .usb_div_misuse(usb_div_misuse));

// >>> src/osd_pkg.sv
package osd_pkg;
    localparam int unsigned CLK_HZ            = 100_000_000;
    // Byte addresses of the two registers on the APB port
    localparam logic [3:0]  ADDR_OSC_CTRL     = 4'h0;
    localparam logic [3:0]  ADDR_CLK_DIV      = 4'h4;
    // Unlock keys
    localparam logic [7:0]  KEY_HI_1          = 8'h78;
    localparam logic [7:0]  KEY_HI_2          = 8'h9a;
    localparam logic [7:0]  KEY_LO_1          = 8'h46;
    localparam logic [7:0]  KEY_LO_2          = 8'h57;
    // Oscillator control field positions
    localparam int unsigned CUR_LSB           = 12;
    localparam int unsigned NEW_LSB           = 8;
    localparam int unsigned CLOCK_SEL_LOCK_BIT       = 7;
    localparam int unsigned IO_LOCK_A_BIT        = 6;
    localparam int unsigned PLLLOCK_BIT       = 5;
    localparam int unsigned CF_BIT            = 3;
    localparam int unsigned PSLEEP_BIT        = 2;
    localparam int unsigned SECEN_BIT         = 1;
    localparam int unsigned SWREQ_BIT         = 0;
    // Clock divider field positions
    localparam int unsigned ROI_BIT           = 15;
    localparam int unsigned DOZE_LSB          = 12;
    localparam int unsigned DOZE_ENABLE_BIT         = 11;
    localparam int unsigned RC_POSTSCALER_LSB         = 8;
    localparam int unsigned USB_BRANCH_SYSCLK_DIV_LSB         = 6;
    localparam int unsigned PLL_ENABLE_BIT         = 5;
    localparam logic [15:0] CLK_DIV_RESET     = 16'h0100;
    localparam logic [15:0] CLK_DIV_WMASK     = 16'hffe0;
    // Source encodings
    localparam logic [2:0]  SRC_FRC           = 3'h0;
    localparam logic [2:0]  SRC_FRC_PLL       = 3'h1;
    localparam logic [2:0]  SRC_PRI           = 3'h2;
    localparam logic [2:0]  SRC_PRI_PLL       = 3'h3;
    localparam logic [2:0]  SRC_SEC           = 3'h4;
    localparam logic [2:0]  SRC_LOW_POWER_RC          = 3'h5;
    localparam logic [2:0]  SRC_RSVD          = 3'h6;
    localparam logic [2:0]  SRC_FRC_DIV       = 3'h7;
    localparam int unsigned SETTLE_CYCLES     = 10;
    localparam int unsigned CNT_W             = 4;
    typedef enum logic [1:0] {
        OSD_IDLE,
        OSD_WAIT_READY,
        OSD_SETTLE
    } osd_sw_state_t;
endpackage

// >>> src/osd_switch_fsm.sv
`timescale 1ns/1ps
module osd_switch_fsm
    import osd_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       start,
    input  wire logic [2:0] new_src,
    input  wire logic [2:0] cur_src,
    input  wire logic       src_ready,
    input  wire logic       new_src_tick,
    output logic            valid_switch,
    output logic            abort,
    output logic            done
);
    osd_sw_state_t          state_reg;
    osd_sw_state_t          state_next;
    logic [CNT_W-1:0]       cnt_reg;
    logic [CNT_W-1:0]       cnt_next;
    wire                    same_src = (new_src == cur_src);
    wire                    last_tick = new_src_tick &&
        (cnt_reg == CNT_W'(SETTLE_CYCLES - 1));

    always_comb
    begin
        state_next   = state_reg;
        cnt_next     = cnt_reg;
        valid_switch = 1'b0;
        abort        = 1'b0;
        done         = 1'b0;
        case (state_reg)
            OSD_IDLE:
            begin
                if (start && same_src)
                    abort = 1'b1;
                else if (start)
                begin
                    valid_switch = 1'b1;
                    state_next   = OSD_WAIT_READY;
                end
            end
            OSD_WAIT_READY:
            begin
                cnt_next = '0;
                if (src_ready)
                    state_next = OSD_SETTLE;
            end
            OSD_SETTLE:
            begin
                if (last_tick)
                begin
                    done       = 1'b1;
                    state_next = OSD_IDLE;
                end
                else if (new_src_tick)
                    cnt_next = cnt_reg + 1'b1;
            end
            default:
                state_next = OSD_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= OSD_IDLE;
            cnt_reg   <= '0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end
endmodule // osd_switch_fsm

// >>> src/osd_top.sv
// Contract
// [RULE1] Software clock switching allowed only when switch-mode cfg upper bit is zero.
// [RULE2] Fail-safe monitor active only when both switch-mode cfg bits are zero.
// [RULE3] Power-on source comes from the initial source cfg field.
// [RULE4] Unprogrammed device starts on divided fast RC, code 111.
// [RULE5] Read-only current-source field reports active clock; 110 reserved.
// [RULE6] Writable new-source field holds the requested next source.
// [RULE7] Reset loads new-source field from initial source cfg.
// [RULE8] Clock lock is set-only; locks selection only while monitor applies.
// [RULE9] I/O lock changes only after unlock; one-way cfg forbids clearing.
// [RULE10] PLL lock reads 1 when locked or timer expired, else 0. Code has no timer: reads 1 only when locked in a PLL mode with PLL enabled.
// [RULE11] PLL lock cleared on valid switch and in non-PLL modes.
// [RULE12] Clock-fail flag set by monitor, clear-only by software, resets 0. Code also clears it on a valid switch.
// [RULE13] Primary sleep enable keeps primary oscillator running in sleep.
// [RULE14] Secondary enable bit turns the 32 kHz oscillator on or off. Code keeps it on while SRC_SEC is the active source, whatever the bit.
// [RULE15] Writing switch request starts switch; hardware clears it when done.
// [RULE16] Recover-on-interrupt lets any interrupt clear doze enable.
// [RULE17] Doze ratio code n gives CPU to peripheral ratio 1:2^n.
// [RULE18] Doze ratio applies only while doze enable is set, else 1:1.
// [RULE19] RC postscaler divides fast RC by 1..64, code 111 by 256.
// [RULE20] USB-branch divider divides 32 MHz branch by 1, 2, 4, 8.
// [RULE21] Software avoids divide-by-4 and 8 while USB is enabled.
// [RULE22] PLL enable bit switches the 96 MHz PLL on or off.
// [RULE23] Byte writes need key pairs 78h,9Ah high and 46h,57h low.
// [RULE24] Same source aborts; else start, wait ready plus 10 clocks, switch.
// [RULE25] With switching disabled, request stays 0 and selection is fixed.
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module osd_top
    import osd_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic [1:0]  switch_monitor_cfg,
    input  wire logic [1:0]  primary_mode_cfg,
    input  wire logic [2:0]  initial_source_cfg,
    input  wire logic        io_lock_one_way_cfg,
    input  wire logic        pll_locked_pin,
    input  wire logic        osc_ready_pin,
    input  wire logic        new_src_clk_pin,
    input  wire logic        clock_failure_pin,
    input  wire logic        sleep_mode,
    input  wire logic        interrupt_event,
    input  wire logic        usb_enabled,
    output logic [2:0]       active_source,
    output logic             fail_safe_monitor,
    output logic             primary_osc_on,
    output logic             secondary_osc_on,
    output logic             pll_on,
    output logic             io_lock_a,
    output logic [2:0]       doze_ratio_log2,
    output logic [7:0]       rc_divisor_m1,
    output logic [2:0]       usb_branch_div_log2,
    output logic             usb_div_misuse
);
    logic [2:0]  cur_reg;
    logic [2:0]  new_reg;
    logic        clock_sel_lock_reg;
    logic        io_lock_a_reg;
    logic        plllock_reg;
    logic        cf_reg;
    logic        psleep_reg;
    logic        secen_reg;
    logic        swreq_reg;
    logic [15:0] div_reg;
    logic [1:0]  key_hi_reg;
    logic [1:0]  key_lo_reg;
    logic        init_reg;
    logic [2:0]  sync_a_reg;
    logic [2:0]  sync_b_reg;
    logic        tick_prev_reg;
    logic        valid_switch;
    logic        sw_abort;
    logic        sw_done;

    function automatic logic is_pll(input logic [2:0] s);
        return (s == SRC_PRI_PLL) || (s == SRC_FRC_PLL);
    endfunction

    // APB decode
    wire acc       = psel && penable;
    wire wr        = acc && pwrite;
    wire rd_setup  = psel && !penable && !pwrite;
    wire hit_osc   = (paddr[31:0] == {28'h0, ADDR_OSC_CTRL});
    wire hit_div   = (paddr[31:0] == {28'h0, ADDR_CLK_DIV});
    wire mapped    = hit_osc || hit_div;
    wire wr_osc    = wr && hit_osc;
    wire wr_div    = wr && hit_div;
    wire [7:0] wlo = pwdata[7:0];
    wire [7:0] whi = pwdata[15:8];
    wire lane_lo   = wr_osc && pstrb[0];
    wire lane_hi   = wr_osc && pstrb[1];

    // Unlock key tracking
    wire hi_key1   = lane_hi && (whi == KEY_HI_1);
    wire hi_key2   = lane_hi && (whi == KEY_HI_2) && key_hi_reg[0];
    wire hi_open   = key_hi_reg[1];
    wire lo_key1   = lane_lo && (wlo == KEY_LO_1);
    wire lo_key2   = lane_lo && (wlo == KEY_LO_2) && key_lo_reg[0];
    wire lo_open   = key_lo_reg[1];
    wire hi_write  = lane_hi && hi_open; // RULE23
    wire lo_write  = lane_lo && lo_open; // RULE23

    // Configuration decode
    wire sw_enable = !switch_monitor_cfg[1]; // RULE1
    assign fail_safe_monitor = (switch_monitor_cfg == 2'b00); // RULE2
    wire sel_locked = clock_sel_lock_reg && fail_safe_monitor; // RULE8

    // Synchronised pins: [0]=pll lock [1]=osc ready [2]=new clk
    wire [2:0] pins_async = {new_src_clk_pin, osc_ready_pin,
                             pll_locked_pin};
    wire pll_lock_s = sync_b_reg[0];
    wire osc_rdy_s  = sync_b_reg[1];
    wire tick       = sync_b_reg[2] && !tick_prev_reg;
    wire fail_s;
    logic [1:0] fail_sync_reg;
    assign fail_s = fail_sync_reg[1];

    wire src_ready = is_pll(new_reg) ? (pll_lock_s && div_reg[PLL_ENABLE_BIT])
                                     : osc_rdy_s;
    wire start = swreq_reg && sw_enable && !sel_locked;

    osd_switch_fsm u_fsm (
        .clock        (clock),
        .rst_n        (rst_n),
        .start        (start),
        .new_src      (new_reg),
        .cur_src      (cur_reg),
        .src_ready    (src_ready),
        .new_src_tick (tick),
        .valid_switch (valid_switch),
        .abort        (sw_abort),
        .done         (sw_done)
    ); // RULE24

    // Register images
    wire [15:0] osc_image = {1'b0, cur_reg, 1'b0, new_reg, clock_sel_lock_reg,
                             io_lock_a_reg, plllock_reg, 1'b0, cf_reg,
                             psleep_reg, secen_reg, swreq_reg};
    wire [15:0] rd_sel = hit_osc ? osc_image :
                         hit_div ? div_reg : 16'h0000;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync_a_reg    <= '0;
            sync_b_reg    <= '0;
            fail_sync_reg <= '0;
            tick_prev_reg <= 1'b0;
        end
        else
        begin
            sync_a_reg    <= pins_async;
            sync_b_reg    <= sync_a_reg;
            fail_sync_reg <= {fail_sync_reg[0], clock_failure_pin};
            tick_prev_reg <= sync_b_reg[2];
        end
    end

    // Key sequence: second key must be the next write to the same byte lane after the first
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            key_hi_reg <= 2'b00;
            key_lo_reg <= 2'b00;
        end
        else
        begin
            if (lane_hi)
                key_hi_reg <= {hi_key2, hi_key1 && !hi_open}; // RULE23
            if (lane_lo)
                key_lo_reg <= {lo_key2, lo_key1 && !lo_open}; // RULE23
        end
    end

    // Strap capture after reset release
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            init_reg <= 1'b1;
            cur_reg  <= SRC_FRC_DIV; // RULE4
            new_reg  <= SRC_FRC_DIV;
        end
        else if (init_reg)
        begin
            init_reg <= 1'b0;
            cur_reg  <= initial_source_cfg; // RULE3 RULE5
            new_reg  <= initial_source_cfg; // RULE7
        end
        else
        begin
            if (sw_done)
                cur_reg <= new_reg; // RULE24 RULE5
            if (hi_write && !sel_locked)
                new_reg <= whi[NEW_LSB-8 +: 3]; // RULE6
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clock_sel_lock_reg <= 1'b0;
            io_lock_a_reg  <= 1'b0;
            cf_reg      <= 1'b0; // RULE12
            psleep_reg  <= 1'b0;
            secen_reg   <= 1'b0;
            swreq_reg   <= 1'b0;
            plllock_reg <= 1'b0;
        end
        else
        begin
            if (lo_write && wlo[CLOCK_SEL_LOCK_BIT])
                clock_sel_lock_reg <= 1'b1; // RULE8
            if (lo_write && (wlo[IO_LOCK_A_BIT] ||
                !(io_lock_one_way_cfg && io_lock_a_reg)))
                io_lock_a_reg <= wlo[IO_LOCK_A_BIT]; // RULE9
            if (fail_safe_monitor && fail_s)
                cf_reg <= 1'b1; // RULE12
            else if (valid_switch ||
                     (lo_write && !wlo[CF_BIT]))
                cf_reg <= 1'b0; // RULE12
            if (lo_write)
            begin
                psleep_reg <= wlo[PSLEEP_BIT];
                secen_reg  <= wlo[SECEN_BIT];
            end
            if (!sw_enable)
                swreq_reg <= 1'b0; // RULE25
            else if (sw_done || sw_abort)
                swreq_reg <= 1'b0; // RULE15
            else if (lo_write && wlo[SWREQ_BIT])
                swreq_reg <= 1'b1; // RULE15
            plllock_reg <= !valid_switch && is_pll(cur_reg) &&
                           div_reg[PLL_ENABLE_BIT] && pll_lock_s; // RULE10 RULE11
        end
    end

    // Clock divider register
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            div_reg <= CLK_DIV_RESET;
        else
        begin
            if (wr_div)
            begin
                if (pstrb[0])
                    div_reg[7:0] <= pwdata[7:0] & CLK_DIV_WMASK[7:0];
                if (pstrb[1])
                    div_reg[15:8] <= pwdata[15:8];
            end
            if (interrupt_event && div_reg[ROI_BIT])
                div_reg[DOZE_ENABLE_BIT] <= 1'b0; // RULE16
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            prdata <= 32'h0000_0000;
        else if (rd_setup)
            prdata <= {16'h0000, rd_sel};
    end

    assign pready  = 1'b1;
    assign pslverr = acc && !mapped;

    // Clock tree controls
    assign active_source    = cur_reg;
    assign primary_osc_on   = (is_pll(cur_reg) || cur_reg == SRC_PRI) &&
                              (!sleep_mode || psleep_reg); // RULE13
    assign secondary_osc_on = secen_reg || cur_reg == SRC_SEC; // RULE14
    assign pll_on           = div_reg[PLL_ENABLE_BIT]; // RULE22
    assign io_lock_a        = io_lock_a_reg;
    assign doze_ratio_log2  = div_reg[DOZE_ENABLE_BIT] ?
                              div_reg[DOZE_LSB +: 3] : 3'h0; // RULE17 RULE18
    wire [2:0] rc_code      = div_reg[RC_POSTSCALER_LSB +: 3];
    assign rc_divisor_m1    = (rc_code == 3'h7) ? 8'hff :
                              8'((9'h001 << rc_code) - 9'h001); // RULE19
    assign usb_branch_div_log2 = {1'b0, div_reg[USB_BRANCH_SYSCLK_DIV_LSB +: 2]}; // RULE20
    assign usb_div_misuse   = usb_enabled &&
                              div_reg[USB_BRANCH_SYSCLK_DIV_LSB + 1]; // RULE21
endmodule // osd_top
